/* core/dvacr_params.svh */
// Register offsets, field positions and reset values of the config bank
`ifndef DVACR_PARAMS_SVH
`define DVACR_PARAMS_SVH

// Register offsets
`define DVACR_OFS_LINK_STREAM   8'h28
`define DVACR_OFS_DITHER_CTRL   8'h29
`define DVACR_OFS_COLOR_TABLE   8'h2A
`define DVACR_OFS_AUDIO_SERIAL  8'h2B
`define DVACR_OFS_RX_CTL        8'h34

// Reset values
`define DVACR_RST_LINK_STREAM   8'h20
`define DVACR_RST_DITHER_CTRL   8'h00
`define DVACR_RST_COLOR_TABLE   8'h00
`define DVACR_RST_AUDIO_SERIAL  8'h00
`define DVACR_RST_RX_MODE       2'h0

// Link stream configuration fields
`define DVACR_LS_LOCK           7
`define DVACR_LS_VID_OFF        5
`define DVACR_LS_DUAL           4
`define DVACR_LS_ALT_AUDIO      3
`define DVACR_LS_AUDIO_OFF      2
`define DVACR_LS_WIDE_VIDEO     1
`define DVACR_LS_SURROUND       0
// Writable bits of the link stream register (bit 6 reserved)
`define DVACR_LS_WMASK          8'hBF
// Bits the forward channel may load (not the lock or status bit)
`define DVACR_LS_FCMASK         8'h1F

// Dither control fields
`define DVACR_DC_SYNC_MODE      7
`define DVACR_DC_HS_INV         6
`define DVACR_DC_VS_INV         5
`define DVACR_DC_DE_INV         4
`define DVACR_DC_STAGE2         3
`define DVACR_DC_STAGE1         2
`define DVACR_DC_HI2_OFF        1
`define DVACR_DC_HI1_OFF        0

// Color table control fields
`define DVACR_CT_PAGE_HI        7
`define DVACR_CT_PAGE_LO        6
`define DVACR_CT_WB_EN          5
`define DVACR_CT_RELOAD         4
`define DVACR_CT_WMASK          8'hF0

// Audio serial control fields
`define DVACR_AS_OVERRUN        3
`define DVACR_AS_UNDERRUN       2
`define DVACR_AS_ERR_CLR        1
`define DVACR_AS_RISE_EDGE      0

// Receiver control fields
`define DVACR_RX_MODE_HI        4
`define DVACR_RX_MODE_LO        3

`endif

/* core/dvacr_pkg.sv */
// Types shared by the config register bank
package dvacr_pkg;

    // Receiver input mode
    typedef enum logic [1:0] {
        DVACR_RX_AUTO,
        DVACR_RX_DUAL,
        DVACR_RX_PRIMARY,
        DVACR_RX_SECONDARY
    } dvacr_rx_mode_type;

    // Color table page
    typedef enum logic [1:0] {
        DVACR_PAGE_CONFIG,
        DVACR_PAGE_RED,
        DVACR_PAGE_GREEN,
        DVACR_PAGE_BLUE
    } dvacr_page_type;

endpackage

/* core/dvacr_flag.sv */
// Sticky status flag, set has priority over clear
`timescale 1ns/1ps
`default_nettype none

module dvacr_flag (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic set_evt,
    input  wire logic clr_evt,
    output var  logic flag_q
);

    logic flag_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        flag_d = flag_q;
        if (clr_evt) begin
            flag_d = 1'b0;
        end
        if (set_evt) begin
            flag_d = 1'b1;
        end
    end

    // Flag register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end

endmodule // dvacr_flag

`default_nettype wire

/* core/dvacr_regs.sv */
// Video, dither, color table and audio configuration register bank
//
// How it works
// - Lock bit set blocks forward-channel reloads; local writes are kept.
// - Video-disabled status resets to one, reads one without active video.
// - Dual-link bit steers forward data recovery while receiver auto-detects.
// - Alternate audio bit puts word clock on GPIO1, data on GPIO0.
// - Wide-video bit treats forward channel as 28-bit video with syncs.
// - Surround bit enables multichannel audio output.
// - Timing select bit: zero data-enable only, one separate syncs.
// - Polarity bits: zero active high, one active low.
// - Bits 3 and 2 enable second and first dither stages.
// - Bits 1 and 0 disable second and first high dither variants.
// - Page field maps config, red, green, blue lookup tables.
// - Bit 5 applies white-balance correction, otherwise bypassed.
// - Bit 4 enables lookup table reloading.
// - Overrun bit 3 and underrun bit 2 are read-only, reset zero.
// - Writing one to bit 1 clears the latched audio FIFO errors.
// - Edge bit: one strobes data on rising clock, zero falling.
// - Receiver mode: auto, forced dual, primary only, secondary only.
`timescale 1ns/1ps
`default_nettype none
`include "dvacr_params.svh"

module dvacr_regs
    import dvacr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // Local register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata_q,
    output var  logic       reg_rvalid_q,
    // Forward channel side
    input  wire logic       fc_load,
    input  wire logic [7:0] fc_data,
    input  wire logic       fc_video_active,
    input  wire logic       fc_dual_detect,
    // Audio FIFO events
    input  wire logic       fifo_overrun_evt,
    input  wire logic       fifo_underrun_evt,
    // Audio and GPIO pins
    input  wire logic       alt_word_clk,
    input  wire logic       alt_serial_data,
    input  wire logic       gpio0_normal,
    input  wire logic       gpio1_normal,
    output var  logic       gpio0_out_q,
    output var  logic       gpio1_out_q,
    // Display timing
    input  wire logic       hsync_in,
    input  wire logic       vsync_in,
    input  wire logic       data_enable_in,
    output var  logic       hsync_out_q,
    output var  logic       vsync_out_q,
    output var  logic       data_enable_out_q,
    // Decoded controls
    output var  logic       local_config_lock_q,
    output var  logic       video_disabled_q,
    output var  logic       link_dual_q,
    output var  logic       link_secondary_q,
    output var  logic       audio_off_q,
    output var  logic       wide_video_q,
    output var  logic       surround_en_q,
    output var  logic       sync_mode_q,
    output var  logic       dither_stage2_en_q,
    output var  logic       dither_stage1_en_q,
    output var  logic       high_dither2_en_q,
    output var  logic       high_dither1_en_q,
    output var  logic [1:0] table_page_q,
    output var  logic [2:0] lut_select_q,
    output var  logic       white_balance_en_q,
    output var  logic       table_reload_en_q,
    output var  logic       fifo_err_clear_q,
    output var  logic       audio_rise_edge_q
);

    // Register state
    logic [7:0] link_stream_q;
    logic [7:0] link_stream_d;
    logic [7:0] dither_ctrl_q;
    logic [7:0] dither_ctrl_d;
    logic [7:0] color_table_q;
    logic [7:0] color_table_d;
    logic       audio_edge_q;
    logic       audio_edge_d;
    dvacr_rx_mode_type rx_mode_q;
    dvacr_rx_mode_type rx_mode_d;
    logic       overrun_q;
    logic       underrun_q;
    logic       err_clr;
    logic [7:0] rdata_d;
    logic       wr_link;
    logic       wr_dither;
    logic       wr_color;
    logic       wr_audio;
    logic       wr_rx;

    // Address decode for the write strobes; the read mux decodes with its own case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Write strobes per register
    assign wr_link   = reg_wr && hit(reg_addr, `DVACR_OFS_LINK_STREAM);
    assign wr_dither = reg_wr && hit(reg_addr, `DVACR_OFS_DITHER_CTRL);
    assign wr_color  = reg_wr && hit(reg_addr, `DVACR_OFS_COLOR_TABLE);
    assign wr_audio  = reg_wr && hit(reg_addr, `DVACR_OFS_AUDIO_SERIAL);
    assign wr_rx     = reg_wr && hit(reg_addr, `DVACR_OFS_RX_CTL);
    // Clear pulse for the latched FIFO errors
    assign err_clr   = wr_audio && reg_wdata[`DVACR_AS_ERR_CLR];

    // Latched audio FIFO errors
    dvacr_flag u_overrun (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .set_evt  (fifo_overrun_evt),
        .clr_evt  (err_clr),
        .flag_q   (overrun_q)
    );

    dvacr_flag u_underrun (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .set_evt  (fifo_underrun_evt),
        .clr_evt  (err_clr),
        .flag_q   (underrun_q)
    );

    // Next register values; local writes win over forward-channel loads
    always_comb begin
        link_stream_d = link_stream_q;
        if (fc_load && !link_stream_q[`DVACR_LS_LOCK]) begin
            link_stream_d = (link_stream_q & ~`DVACR_LS_FCMASK)
                          | (fc_data & `DVACR_LS_FCMASK);
        end
        if (wr_link) begin
            link_stream_d = reg_wdata & `DVACR_LS_WMASK;
        end
        // Status follows the forward channel's video state
        link_stream_d[`DVACR_LS_VID_OFF] = !fc_video_active;
        dither_ctrl_d = wr_dither ? reg_wdata : dither_ctrl_q;
        color_table_d = color_table_q;
        if (wr_color) begin
            color_table_d = reg_wdata & `DVACR_CT_WMASK;
        end
        audio_edge_d = wr_audio ? reg_wdata[`DVACR_AS_RISE_EDGE]
                                : audio_edge_q;
        rx_mode_d = rx_mode_q;
        if (wr_rx) begin
            rx_mode_d = dvacr_rx_mode_type'(
                reg_wdata[`DVACR_RX_MODE_HI:`DVACR_RX_MODE_LO]);
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_stream_q <= `DVACR_RST_LINK_STREAM;
            dither_ctrl_q <= `DVACR_RST_DITHER_CTRL;
            color_table_q <= `DVACR_RST_COLOR_TABLE;
            audio_edge_q  <= 1'b0;
            rx_mode_q     <= DVACR_RX_AUTO;
        end else if (clk_en) begin
            link_stream_q <= link_stream_d;
            dither_ctrl_q <= dither_ctrl_d;
            color_table_q <= color_table_d;
            audio_edge_q  <= audio_edge_d;
            rx_mode_q     <= rx_mode_d;
        end
    end

    // Read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            `DVACR_OFS_LINK_STREAM: begin
                rdata_d = link_stream_q;
            end
            `DVACR_OFS_DITHER_CTRL: begin
                rdata_d = dither_ctrl_q;
            end
            `DVACR_OFS_COLOR_TABLE: begin
                rdata_d = color_table_q;
            end
            `DVACR_OFS_AUDIO_SERIAL: begin
                rdata_d[`DVACR_AS_OVERRUN]    = overrun_q;
                rdata_d[`DVACR_AS_UNDERRUN]   = underrun_q;
                rdata_d[`DVACR_AS_RISE_EDGE]  = audio_edge_q;
            end
            `DVACR_OFS_RX_CTL: begin
                rdata_d[`DVACR_RX_MODE_HI:`DVACR_RX_MODE_LO] = rx_mode_q;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

    // Decoded control values and pin paths
    logic       dual_d;
    logic       secondary_d;
    logic       gpio0_d;
    logic       gpio1_d;
    logic [2:0] lut_d;
    logic       alt_en;
    dvacr_page_type page;

    assign alt_en = link_stream_q[`DVACR_LS_ALT_AUDIO];
    assign page   = dvacr_page_type'(
        color_table_q[`DVACR_CT_PAGE_HI:`DVACR_CT_PAGE_LO]);

    always_comb begin
        // Link selection: auto mode takes the dual-link bit ORed with fc_dual_detect
        dual_d      = 1'b0;
        secondary_d = 1'b0;
        case (rx_mode_q)
            DVACR_RX_AUTO: begin
                dual_d = link_stream_q[`DVACR_LS_DUAL]
                       | fc_dual_detect;
            end
            DVACR_RX_DUAL: begin
                dual_d = 1'b1;
            end
            DVACR_RX_PRIMARY: begin
                dual_d = 1'b0;
            end
            DVACR_RX_SECONDARY: begin
                secondary_d = 1'b1;
            end
            default: begin
                dual_d = 1'b0;
            end
        endcase
        // GPIO pins carry the alternate audio port when enabled
        gpio1_d = alt_en ? alt_word_clk : gpio1_normal;
        gpio0_d = alt_en ? alt_serial_data : gpio0_normal;
        // One-hot table select, zero on the configuration page
        lut_d = 3'h0;
        case (page)
            DVACR_PAGE_CONFIG: begin
                lut_d = 3'h0;
            end
            DVACR_PAGE_RED: begin
                lut_d = 3'h1;
            end
            DVACR_PAGE_GREEN: begin
                lut_d = 3'h2;
            end
            DVACR_PAGE_BLUE: begin
                lut_d = 3'h4;
            end
            default: begin
                lut_d = 3'h0;
            end
        endcase
    end

    // Registered outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            local_config_lock_q <= 1'b0;
            video_disabled_q    <= 1'b1;
            link_dual_q         <= 1'b0;
            link_secondary_q    <= 1'b0;
            audio_off_q         <= 1'b0;
            wide_video_q        <= 1'b0;
            surround_en_q       <= 1'b0;
            sync_mode_q         <= 1'b0;
            dither_stage2_en_q  <= 1'b0;
            dither_stage1_en_q  <= 1'b0;
            high_dither2_en_q   <= 1'b1;
            high_dither1_en_q   <= 1'b1;
            table_page_q        <= 2'h0;
            lut_select_q        <= 3'h0;
            white_balance_en_q  <= 1'b0;
            table_reload_en_q   <= 1'b0;
            fifo_err_clear_q    <= 1'b0;
            audio_rise_edge_q   <= 1'b0;
            gpio0_out_q         <= 1'b0;
            gpio1_out_q         <= 1'b0;
            hsync_out_q         <= 1'b0;
            vsync_out_q         <= 1'b0;
            data_enable_out_q   <= 1'b0;
        end else if (clk_en) begin
            local_config_lock_q <= link_stream_q[`DVACR_LS_LOCK];
            video_disabled_q    <= link_stream_q[`DVACR_LS_VID_OFF];
            link_dual_q         <= dual_d;
            link_secondary_q    <= secondary_d;
            audio_off_q         <= link_stream_q[`DVACR_LS_AUDIO_OFF];
            wide_video_q <= link_stream_q[`DVACR_LS_WIDE_VIDEO];
            surround_en_q       <= link_stream_q[`DVACR_LS_SURROUND];
            sync_mode_q         <= dither_ctrl_q[`DVACR_DC_SYNC_MODE];
            dither_stage2_en_q  <= dither_ctrl_q[`DVACR_DC_STAGE2];
            dither_stage1_en_q  <= dither_ctrl_q[`DVACR_DC_STAGE1];
            high_dither2_en_q   <= !dither_ctrl_q[`DVACR_DC_HI2_OFF];
            high_dither1_en_q   <= !dither_ctrl_q[`DVACR_DC_HI1_OFF];
            table_page_q        <= page;
            lut_select_q        <= lut_d;
            white_balance_en_q  <= color_table_q[`DVACR_CT_WB_EN];
            table_reload_en_q   <= color_table_q[`DVACR_CT_RELOAD];
            fifo_err_clear_q    <= err_clr;
            audio_rise_edge_q   <= audio_edge_q;
            gpio0_out_q         <= gpio0_d;
            gpio1_out_q         <= gpio1_d;
            // Polarity applied; syncs held inactive in data-enable mode
            hsync_out_q <= (hsync_in & dither_ctrl_q[`DVACR_DC_SYNC_MODE])
                         ^ dither_ctrl_q[`DVACR_DC_HS_INV];
            vsync_out_q <= (vsync_in & dither_ctrl_q[`DVACR_DC_SYNC_MODE])
                         ^ dither_ctrl_q[`DVACR_DC_VS_INV];
            data_enable_out_q <= data_enable_in
                         ^ dither_ctrl_q[`DVACR_DC_DE_INV];
        end
    end

endmodule // dvacr_regs

`default_nettype wire

/* bench/dvacr_regs_asserts.sv */
// Concurrent checks on the config register bank ports
`timescale 1ns/1ps
`default_nettype none

module dvacr_regs_asserts (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic       reg_rvalid_q,
    input wire logic       fc_load,
    input wire logic       fc_video_active,
    input wire logic       fifo_overrun_evt,
    input wire logic       video_disabled_q,
    input wire logic       dither_stage2_en_q,
    input wire logic       dither_stage1_en_q,
    input wire logic       high_dither2_en_q,
    input wire logic       high_dither1_en_q,
    input wire logic [1:0] table_page_q,
    input wire logic [2:0] lut_select_q,
    input wire logic       white_balance_en_q,
    input wire logic       table_reload_en_q,
    input wire logic       fifo_err_clear_q,
    input wire logic       audio_rise_edge_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Reads of unmapped offsets answer zero
    unmapped_read_a: assert property (
        clk_en && reg_rd &&
        !(reg_addr inside {8'h28, 8'h29, 8'h2A, 8'h2B, 8'h34})
        |=> reg_rvalid_q && reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    audio_rsvd_a: assert property (
        clk_en && reg_rd && reg_addr == 8'h2B
        |=> reg_rdata_q[7:4] == 4'h0 && !reg_rdata_q[1])
        else $error("audio control reserved bits set");
    color_rsvd_a: assert property (
        clk_en && reg_rd && reg_addr == 8'h2A |=> reg_rdata_q[3:0] == 4'h0)
        else $error("color table reserved bits set");
    // Status follows the absence of video
    video_off_a: assert property (
        (clk_en && !fc_video_active) [*3] |-> video_disabled_q)
        else $error("video disabled status low without video");
    dither_map_a: assert property (
        (clk_en && reg_wr && reg_addr == 8'h29) ##1 (clk_en && !reg_wr)
        |=> dither_stage2_en_q == $past(reg_wdata[3], 2) &&
            dither_stage1_en_q == $past(reg_wdata[2], 2) &&
            high_dither2_en_q == !$past(reg_wdata[1], 2) &&
            high_dither1_en_q == !$past(reg_wdata[0], 2))
        else $error("dither controls differ from written value");
    table_map_a: assert property (
        (clk_en && reg_wr && reg_addr == 8'h2A) ##1 (clk_en && !reg_wr)
        |=> table_page_q == $past(reg_wdata[7:6], 2) &&
            white_balance_en_q == $past(reg_wdata[5], 2) &&
            table_reload_en_q == $past(reg_wdata[4], 2) &&
            lut_select_q == ((table_page_q == 2'h0) ? 3'h0 :
                             3'h1 << (table_page_q - 2'h1)))
        else $error("color table controls differ from written value");
    edge_sel_a: assert property (
        (clk_en && reg_wr && reg_addr == 8'h2B) ##1 (clk_en && !reg_wr)
        |=> audio_rise_edge_q == $past(reg_wdata[0], 2))
        else $error("audio edge select differs from written value");
    err_clear_a: assert property (
        clk_en && reg_wr && reg_addr == 8'h2B && reg_wdata[1]
        |=> fifo_err_clear_q)
        else $error("fifo error clear pulse missing");
    overrun_set_a: assert property (
        (clk_en && fifo_overrun_evt) ##1 (clk_en && !reg_wr)
        ##1 (clk_en && reg_rd && reg_addr == 8'h2B) |=> reg_rdata_q[3])
        else $error("overrun flag not reported");
    // A locked register ignores a forward channel load
    lock_keep_a: assert property (
        (clk_en && reg_wr && reg_addr == 8'h28 && reg_wdata[7])
        ##1 (clk_en && !reg_wr) ##1 (clk_en && fc_load && !reg_wr)
        ##1 (clk_en && !reg_wr)
        ##1 (clk_en && reg_rd && !reg_wr && reg_addr == 8'h28)
        |=> reg_rdata_q[4:0] == $past(reg_wdata[4:0], 5))
        else $error("locked link register reloaded");
endmodule // dvacr_regs_asserts

bind dvacr_regs dvacr_regs_asserts dvacr_regs_asserts_i (
    .core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .reg_rvalid_q, .fc_load, .fc_video_active,
    .fifo_overrun_evt, .video_disabled_q, .dither_stage2_en_q,
    .dither_stage1_en_q, .high_dither2_en_q, .high_dither1_en_q,
    .table_page_q, .lut_select_q, .white_balance_en_q, .table_reload_en_q,
    .fifo_err_clear_q, .audio_rise_edge_q);

`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the config register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic       core_clk, rst_n, clk_en, reg_wr, reg_rd, fc_load;
    logic       fc_video_active, fc_dual_detect, hsync_in, vsync_in;
    logic       fifo_overrun_evt, fifo_underrun_evt, data_enable_in;
    logic       alt_word_clk, alt_serial_data, gpio0_normal, gpio1_normal;
    logic [7:0] reg_addr, reg_wdata, fc_data, reg_rdata_q;
    logic       reg_rvalid_q, gpio0_out_q, gpio1_out_q, hsync_out_q;
    logic       vsync_out_q, data_enable_out_q, local_config_lock_q;
    logic       video_disabled_q, link_dual_q, link_secondary_q;
    logic       audio_off_q, wide_video_q, surround_en_q, sync_mode_q;
    logic       dither_stage2_en_q, dither_stage1_en_q, high_dither2_en_q;
    logic       high_dither1_en_q, white_balance_en_q, table_reload_en_q;
    logic       fifo_err_clear_q, audio_rise_edge_q;
    logic [1:0] table_page_q;
    logic [2:0] lut_select_q;
    int         err_count = 0;
    int         comparisons = 0;

    // Packed views of the decoded controls
    wire logic [7:0] dith_view = {hsync_out_q, vsync_out_q,
        data_enable_out_q, sync_mode_q, dither_stage2_en_q,
        dither_stage1_en_q, high_dither2_en_q, high_dither1_en_q};
    wire logic [7:0] page_view = {1'b0, lut_select_q, table_page_q,
        white_balance_en_q, table_reload_en_q};

    dvacr_regs dvacr_regs_i (.core_clk, .rst_n, .clk_en, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .reg_rvalid_q, .fc_load,
        .fc_data, .fc_video_active, .fc_dual_detect, .fifo_overrun_evt,
        .fifo_underrun_evt, .alt_word_clk, .alt_serial_data, .gpio0_normal,
        .gpio1_normal, .gpio0_out_q, .gpio1_out_q, .hsync_in, .vsync_in,
        .data_enable_in, .hsync_out_q, .vsync_out_q, .data_enable_out_q,
        .local_config_lock_q, .video_disabled_q, .link_dual_q,
        .link_secondary_q, .audio_off_q, .wide_video_q, .surround_en_q,
        .sync_mode_q, .dither_stage2_en_q, .dither_stage1_en_q,
        .high_dither2_en_q, .high_dither1_en_q, .table_page_q, .lut_select_q,
        .white_balance_en_q, .table_reload_en_q, .fifo_err_clear_q,
        .audio_rise_edge_q);

    // 100 MHz clock
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    // Read, wait a bounded time for the answer, compare it
    task rd(input logic [7:0] a, input logic [7:0] e);
        int n;
        @(negedge core_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge core_clk);
        reg_rd = 1'b0;
        n = 0;
        while (reg_rvalid_q !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h00, reg_rvalid_q}, 8'h01);
        chk(reg_rdata_q, e);
    endtask

    task fc(input logic [7:0] d);
        @(negedge core_clk);
        {fc_load, fc_data} = {1'b1, d};
        @(negedge core_clk);
        fc_load = 1'b0;
    endtask

    // Lets decoded outputs follow a register change
    task settle;
        repeat (3) @(negedge core_clk);
    endtask

    task t_reset;
        chk(8'(video_disabled_q), 8'h01);
        chk(8'({high_dither2_en_q, high_dither1_en_q}), 8'h03);
        rd(8'h28, 8'h20);
        rd(8'h29, 8'h00);
        rd(8'h2A, 8'h00);
        rd(8'h2B, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset done");
    endtask

    task t_lock;
        wr(8'h28, 8'h9B);
        fc(8'h04);
        rd(8'h28, 8'hBB);
        chk(8'({local_config_lock_q, link_dual_q, wide_video_q,
            surround_en_q}), 8'h0F);
        wr(8'h28, 8'h44);
        rd(8'h28, 8'h24);
        chk(8'({local_config_lock_q, audio_off_q}), 8'h01);
        fc(8'h1B);
        rd(8'h28, 8'h3B);
        $display("test lock done");
    endtask

    task t_alt;
        {alt_word_clk, alt_serial_data, gpio1_normal, gpio0_normal} = 4'h9;
        wr(8'h28, 8'h08);
        settle();
        chk(8'({gpio1_out_q, gpio0_out_q}), 8'h02);
        wr(8'h28, 8'h00);
        settle();
        chk(8'({gpio1_out_q, gpio0_out_q}), 8'h01);
        $display("test alt audio done");
    endtask

    task t_video;
        fc_video_active = 1'b1;
        settle();
        chk(8'(video_disabled_q), 8'h00);
        wr(8'h28, 8'h20);
        rd(8'h28, 8'h00);
        fc_video_active = 1'b0;
        settle();
        chk(8'(video_disabled_q), 8'h01);
        $display("test video status done");
    endtask

    task automatic t_dither;
        logic [7:0] dw [5] = '{8'h00, 8'hF0, 8'h8C, 8'h13, 8'h65};
        logic [7:0] dx [5] = '{8'h23, 8'h13, 8'hFF, 8'h00, 8'hE6};
        {hsync_in, vsync_in, data_enable_in} = 3'h7;
        for (int i = 0; i < 5; i++) begin
            wr(8'h29, dw[i]);
            settle();
            chk(dith_view, dx[i]);
            rd(8'h29, dw[i]);
        end
        clk_en = 1'b0;
        wr(8'h29, 8'hFF);
        clk_en = 1'b1;
        rd(8'h29, 8'h65);
        $display("test dither done");
    endtask

    task automatic t_page;
        logic [2:0] lx [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        for (int p = 0; p < 4; p++) begin
            wr(8'h2A, {p[1:0], p[0], p[1], 4'hF});
            settle();
            chk(page_view,
                {1'b0, lx[p], p[1:0], p[0], p[1]});
            rd(8'h2A, {p[1:0], p[0], p[1], 4'h0});
        end
        $display("test page done");
    endtask

    task t_fifo;
        fifo_overrun_evt = 1'b1;
        @(negedge core_clk);
        fifo_overrun_evt = 1'b0;
        rd(8'h2B, 8'h08);
        fifo_underrun_evt = 1'b1;
        @(negedge core_clk);
        fifo_underrun_evt = 1'b0;
        rd(8'h2B, 8'h0C);
        wr(8'h2B, 8'hFF);
        chk(8'(fifo_err_clear_q), 8'h01);
        rd(8'h2B, 8'h01);
        chk(8'(audio_rise_edge_q), 8'h01);
        // Event and clearing write together: the event wins
        @(negedge core_clk);
        {reg_addr, reg_wdata, reg_wr, fifo_overrun_evt} = {16'h2B02, 2'h3};
        @(negedge core_clk);
        {reg_wr, fifo_overrun_evt} = 2'h0;
        rd(8'h2B, 8'h08);
        chk(8'(audio_rise_edge_q), 8'h00);
        $display("test fifo done");
    endtask

    task automatic t_rx;
        logic [7:0] rx [4] = '{8'h02, 8'h02, 8'h00, 8'h01};
        wr(8'h28, 8'h00);
        fc_dual_detect = 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(8'h34, {3'h7, m[1:0], 3'h7});
            settle();
            chk(8'({link_dual_q, link_secondary_q}), rx[m]);
            rd(8'h34, {3'h0, m[1:0], 3'h0});
        end
        wr(8'h34, 8'h00);
        settle();
        chk(8'(link_dual_q), 8'h01);
        fc_dual_detect = 1'b0;
        wr(8'h28, 8'h10);
        settle();
        chk(8'(link_dual_q), 8'h01);
        wr(8'h28, 8'h00);
        settle();
        chk(8'(link_dual_q), 8'h00);
        $display("test receiver mode done");
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence: reset for 16 cycles, then each test
    initial begin
        {rst_n, reg_wr, reg_rd, fc_load, fc_video_active, fc_dual_detect,
         fifo_overrun_evt, fifo_underrun_evt, alt_word_clk, alt_serial_data,
         gpio0_normal, gpio1_normal, hsync_in, vsync_in,
         data_enable_in} = '0;
        {reg_addr, reg_wdata, fc_data} = '0;
        clk_en = 1'b1;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_lock();
        t_alt();
        t_video();
        t_dither();
        t_page();
        t_fifo();
        t_rx();
        wrap_up();
    end

    // Tests need well under 1000 cycles; 5000 means a hang
    initial begin
        #50000;
        err_count++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
